//--- crs_regs.sv
// Processor register set, effective address formation and condition flags
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module crs_regs
   import crs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Arithmetic result update
   input  wire logic        alu_valid,
   input  wire logic [2:0]  alu_op,
   input  wire logic        alu_wide,
   input  wire logic [15:0] alu_a,
   input  wire logic [15:0] alu_b,
   // Addressing
   input  wire logic        direct_mode,
   input  wire logic [7:0]  direct_low,
   input  wire logic        index_mode,
   input  wire logic        rel_mode,
   input  wire logic [1:0]  index_base,
   input  wire logic [1:0]  index_mod,
   input  wire logic [15:0] index_offset,
   input  wire logic        user_push,
   input  wire logic        user_pull,
   // Instruction pointer and hardware stack
   input  wire logic        ip_load,
   input  wire logic [15:0] ip_value,
   input  wire logic [1:0]  stack_op,
   input  wire logic [2:0]  service_kind,
   // Interrupt lines, active low
   input  wire logic        fast_interrupt_line_n,
   input  wire logic        normal_interrupt_line_n,
   // Outputs
   output logic [15:0] addr_out,
   output logic [15:0] alu_result,
   output logic [7:0]  flags_out,
   output logic        fast_irq_take,
   output logic        norm_irq_take
);
   logic [7:0]  acc_a_reg, acc_b_reg, dpb_reg, flags_reg, flags_next;
   logic [15:0] idx_x_reg, idx_y_reg, usp_reg, hsp_reg, ip_reg;

   wire [15:0] acc_d = {acc_a_reg, acc_b_reg};
   wire        wr_a  = reg_wr && reg_addr == CRS_SEL_ACC_A;
   wire        wr_b  = reg_wr && reg_addr == CRS_SEL_ACC_B;
   wire        wr_d  = reg_wr && reg_addr == CRS_SEL_ACC_D;

   // Index base mux; instruction pointer replaces it in relative mode
   wire [15:0] base_sel = rel_mode ? ip_reg :
                          index_base == CRS_BASE_X ? idx_x_reg :
                          index_base == CRS_BASE_Y ? idx_y_reg :
                          index_base == CRS_BASE_U ? usp_reg : hsp_reg;
   wire [15:0] eff_addr = base_sel + index_offset;
   wire        do_idx   = index_mode && !rel_mode && index_mod != CRS_MOD_NONE;
   wire [15:0] base_upd = index_mod == CRS_MOD_INC ? base_sel + 16'h0001
                                                   : base_sel - 16'h0001;
   wire upd_x = do_idx && index_base == CRS_BASE_X;
   wire upd_y = do_idx && index_base == CRS_BASE_Y;
   wire upd_u = do_idx && index_base == CRS_BASE_U;
   wire upd_s = do_idx && index_base == CRS_BASE_S;

   // Arithmetic: subtract forms add the inverted operand with inverted carry
   wire        is_sub  = alu_op == CRS_OP_SUB || alu_op == CRS_OP_SBC ||
                         alu_op == CRS_OP_CMP || alu_op == CRS_OP_NEG;
   wire [15:0] opa     = alu_op == CRS_OP_NEG ? 16'h0000 : alu_a;
   wire [15:0] opb     = alu_op == CRS_OP_NEG ? ~alu_a : (is_sub ? ~alu_b : alu_b);
   wire        cin     = (alu_op == CRS_OP_ADC) ? flags_reg[CRS_FLG_C] :
                         (alu_op == CRS_OP_SBC) ? ~flags_reg[CRS_FLG_C] : is_sub;
   wire [16:0] sum16   = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
   wire [8:0]  sum8    = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
   wire [7:0]  low7    = {1'b0, opa[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
   wire [15:0] low15   = {1'b0, opa[14:0]} + {1'b0, opb[14:0]} + {15'h0000, cin};
   wire [4:0]  nib     = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
   wire [15:0] res     = alu_op == CRS_OP_LOG ? alu_a :
                         (alu_wide ? sum16[15:0] : {8'h00, sum8[7:0]});
   wire        cout    = alu_wide ? sum16[16] : sum8[8];
   wire        cinto   = alu_wide ? low15[15] : low7[7];
   wire        res_msb = alu_wide ? res[15] : res[7];
   wire        res_z   = alu_wide ? res == 16'h0000 : res[7:0] == 8'h00;
   wire        arith   = alu_op != CRS_OP_LOG && alu_op != CRS_OP_NONE;
   wire        half_op = !alu_wide && (alu_op == CRS_OP_ADD || alu_op == CRS_OP_ADC);

   // Service entry masks; unmaskable and fast also raise the fast mask
   wire svc_sets_i = service_kind == CRS_SVC_UNMSK || service_kind == CRS_SVC_FAST ||
                     service_kind == CRS_SVC_NORM  || service_kind == CRS_SVC_TRAP;
   wire svc_sets_f = service_kind == CRS_SVC_UNMSK || service_kind == CRS_SVC_FAST;
   wire norm_req   = !normal_interrupt_line_n && !flags_reg[CRS_FLG_I];
   wire fast_req   = !fast_interrupt_line_n && !flags_reg[CRS_FLG_F];

   always_comb
   begin
      flags_next = flags_reg;
      if (reg_wr && reg_addr == CRS_SEL_FLAGS)
      begin
         flags_next = reg_wdata[7:0];
      end
      else if (alu_valid && alu_op != CRS_OP_NONE)
      begin
         flags_next[CRS_FLG_N] = res_msb;
         flags_next[CRS_FLG_Z] = res_z;
         if (arith)
         begin
            flags_next[CRS_FLG_C] = is_sub ? ~cout : cout;
            flags_next[CRS_FLG_V] = cout ^ cinto;
         end
         else
         begin
            flags_next[CRS_FLG_V] = 1'b0;
         end
         if (half_op)
         begin
            flags_next[CRS_FLG_H] = nib[4];
         end
      end
      if (svc_sets_i)
      begin
         flags_next[CRS_FLG_I] = 1'b1;
      end
      if (svc_sets_f)
      begin
         flags_next[CRS_FLG_F] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         acc_a_reg <= 8'h00;
         acc_b_reg <= 8'h00;
         dpb_reg   <= CRS_DPB_RST;
         flags_reg <= CRS_FLAGS_RST;
         idx_x_reg <= CRS_WORD_RST;
         idx_y_reg <= CRS_WORD_RST;
         usp_reg   <= CRS_WORD_RST;
         hsp_reg   <= CRS_WORD_RST;
         ip_reg    <= CRS_WORD_RST;
      end
      else if (clk_en)
      begin
         flags_reg <= flags_next;
         if (wr_a || wr_d)
            acc_a_reg <= wr_d ? reg_wdata[15:8] : reg_wdata[7:0];
         if (wr_b || wr_d)
            acc_b_reg <= reg_wdata[7:0];
         if (reg_wr && reg_addr == CRS_SEL_DPB)
            dpb_reg <= reg_wdata[7:0];
         if (reg_wr && reg_addr == CRS_SEL_IDX_X)
            idx_x_reg <= reg_wdata;
         else if (upd_x)
            idx_x_reg <= base_upd;
         if (reg_wr && reg_addr == CRS_SEL_IDX_Y)
            idx_y_reg <= reg_wdata;
         else if (upd_y)
            idx_y_reg <= base_upd;
         // User stack moves only on explicit instruction requests
         if (reg_wr && reg_addr == CRS_SEL_USP)
            usp_reg <= reg_wdata;
         else if (upd_u)
            usp_reg <= base_upd;
         else if (user_push)
            usp_reg <= usp_reg - 16'h0001;
         else if (user_pull)
            usp_reg <= usp_reg + 16'h0001;
         // Pre-decrement push keeps the pointer on the last stored byte
         if (reg_wr && reg_addr == CRS_SEL_HSP)
            hsp_reg <= reg_wdata;
         else if (stack_op == CRS_STK_PUSH)
            hsp_reg <= hsp_reg - 16'h0001;
         else if (stack_op == CRS_STK_PULL)
            hsp_reg <= hsp_reg + 16'h0001;
         else if (upd_s)
            hsp_reg <= base_upd;
         if (reg_wr && reg_addr == CRS_SEL_IPTR)
            ip_reg <= reg_wdata;
         else if (ip_load)
            ip_reg <= ip_value;
      end
   end

   // Read mux, answered in the next cycle
   wire [15:0] rd_mux =
      reg_addr == CRS_SEL_ACC_A ? {8'h00, acc_a_reg} :
      reg_addr == CRS_SEL_ACC_B ? {8'h00, acc_b_reg} :
      reg_addr == CRS_SEL_DPB   ? {8'h00, dpb_reg} :
      reg_addr == CRS_SEL_FLAGS ? {8'h00, flags_reg} :
      reg_addr == CRS_SEL_IDX_X ? idx_x_reg :
      reg_addr == CRS_SEL_IDX_Y ? idx_y_reg :
      reg_addr == CRS_SEL_USP   ? usp_reg :
      reg_addr == CRS_SEL_HSP   ? hsp_reg :
      reg_addr == CRS_SEL_IPTR  ? ip_reg :
      reg_addr == CRS_SEL_ACC_D ? acc_d : 16'h0000;

   wire [15:0] addr_next = direct_mode ? {dpb_reg, direct_low} :
                           (index_mode || rel_mode) ? eff_addr : ip_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         reg_rdata     <= 16'h0000;
         addr_out      <= 16'h0000;
         alu_result    <= 16'h0000;
         flags_out     <= CRS_FLAGS_RST;
         fast_irq_take <= 1'b0;
         norm_irq_take <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_rdata     <= reg_rd ? rd_mux : 16'h0000;
         addr_out      <= addr_next;
         alu_result    <= res;
         flags_out     <= flags_next;
         fast_irq_take <= fast_req;
         norm_irq_take <= norm_req && !fast_req;
      end
   end

   dp_clear_a: assert property (@(posedge clk_sys)
      !rstn |=> dpb_reg == 8'h00)
      else $error("direct page base not cleared by reset");
   dp_drive_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && direct_mode |=> addr_out[15:8] == $past(dpb_reg))
      else $error("direct page base not on upper address");
   irq_mask_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && flags_reg[CRS_FLG_I] |=> !norm_irq_take)
      else $error("masked normal interrupt taken");
   fast_interrupt_line_mask_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && flags_reg[CRS_FLG_F] |=> !fast_irq_take)
      else $error("masked fast interrupt taken");
   usp_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && !upd_u && !user_push && !user_pull |=> $stable(usp_reg))
      else $error("user stack pointer moved by itself");
   push_dec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && stack_op == CRS_STK_PUSH |=> hsp_reg == $past(hsp_reg) - 16'h0001)
      else $error("hardware push did not decrement");
   zero_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && alu_valid && alu_op != CRS_OP_NONE
      |=> flags_reg[CRS_FLG_Z] == (alu_result == 16'h0000 || (!$past(alu_wide)
          && alu_result[7:0] == 8'h00)))
      else $error("zero flag mismatch");
   neg_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && alu_valid && !alu_wide && alu_op != CRS_OP_NONE
      |=> flags_reg[CRS_FLG_N] == alu_result[7])
      else $error("negative flag mismatch");
   trap_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && (service_kind == CRS_SVC_TRAP2 || service_kind == CRS_SVC_TRAP3)
      |=> flags_reg[CRS_FLG_I] == $past(flags_reg[CRS_FLG_I]))
      else $error("trap two or three changed normal mask");
   trap_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && svc_sets_i |=> flags_reg[CRS_FLG_I])
      else $error("service entry did not set normal mask");

   // Reference sums for the flag checks, kept apart from the datapath
   wire [8:0] chk_add8 = {1'b0, alu_a[7:0]} + {1'b0, alu_b[7:0]};
   wire [4:0] chk_nib  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};

   sequence byte_add_s;
      clk_en && !reg_wr && alu_valid && !alu_wide && alu_op == CRS_OP_ADD;
   endsequence
   sequence byte_sub_s;
      clk_en && !reg_wr && alu_valid && !alu_wide && alu_op == CRS_OP_SUB;
   endsequence

   rd_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   accd_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && reg_rd && reg_addr == CRS_SEL_ACC_D
      |=> reg_rdata == {$past(acc_a_reg), $past(acc_b_reg)})
      else $error("paired accumulator read wrong");
   accd_high_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == CRS_SEL_ACC_D |=> acc_a_reg == $past(reg_wdata[15:8]))
      else $error("paired write upper byte wrong");
   accd_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == CRS_SEL_ACC_D |=> acc_b_reg == $past(reg_wdata[7:0]))
      else $error("paired write lower byte wrong");
   freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !clk_en |=> $stable(flags_reg) && $stable(acc_a_reg) && $stable(addr_out)
      && $stable(reg_rdata))
      else $error("state moved while clock enable low");
   idx_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && index_mode && !rel_mode && !direct_mode && index_base == CRS_BASE_X
      |=> addr_out == $past(idx_x_reg) + $past(index_offset))
      else $error("indexed address wrong");
   idx_inc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && upd_x && index_mod == CRS_MOD_INC
      |=> idx_x_reg == $past(idx_x_reg) + 16'h0001)
      else $error("index increment wrong");
   idx_dec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && upd_x && index_mod == CRS_MOD_DEC
      |=> idx_x_reg == $past(idx_x_reg) - 16'h0001)
      else $error("index decrement wrong");
   base_u_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !rel_mode && index_base == CRS_BASE_U |-> base_sel == usp_reg)
      else $error("user stack not selected as base");
   base_s_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !rel_mode && index_base == CRS_BASE_S |-> base_sel == hsp_reg)
      else $error("hardware stack not selected as base");
   pull_inc_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && stack_op == CRS_STK_PULL |=> hsp_reg == $past(hsp_reg) + 16'h0001)
      else $error("hardware pull did not increment");
   upush_dec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && !upd_u && user_push |=> usp_reg == $past(usp_reg) - 16'h0001)
      else $error("user push did not decrement");
   rel_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && rel_mode && !direct_mode
      |=> addr_out == $past(ip_reg) + $past(index_offset))
      else $error("relative address wrong");
   ip_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && ip_load |=> ip_reg == $past(ip_value))
      else $error("instruction pointer load wrong");
   carry_add_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      byte_add_s |=> flags_reg[CRS_FLG_C] == $past(chk_add8[8]))
      else $error("add carry wrong");
   borrow_sub_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      byte_sub_s |=> flags_reg[CRS_FLG_C] == $past(alu_a[7:0] < alu_b[7:0]))
      else $error("subtract borrow wrong");
   ovf_add_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      byte_add_s |=> flags_reg[CRS_FLG_V]
      == $past(alu_a[7] == alu_b[7] && chk_add8[7] != alu_a[7]))
      else $error("add overflow wrong");
   half_add_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      byte_add_s |=> flags_reg[CRS_FLG_H] == $past(chk_nib[4]))
      else $error("half carry wrong");
   half_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !reg_wr && (alu_wide || (alu_op != CRS_OP_ADD && alu_op != CRS_OP_ADC))
      |=> $stable(flags_reg[CRS_FLG_H]))
      else $error("half carry moved outside byte add");
   fast_take_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !fast_interrupt_line_n && !flags_reg[CRS_FLG_F] |=> fast_irq_take)
      else $error("unmasked fast interrupt not taken");
   norm_take_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      clk_en && !normal_interrupt_line_n && !flags_reg[CRS_FLG_I] && fast_interrupt_line_n
      |=> norm_irq_take)
      else $error("unmasked normal interrupt not taken");
endmodule

//--- crs_pkg.sv
// Constants for the processor register set and condition flag block
package crs_pkg;
   // Register selectors on the plain register port
   localparam logic [3:0] CRS_SEL_ACC_A  = 4'h0;
   localparam logic [3:0] CRS_SEL_ACC_B  = 4'h1;
   localparam logic [3:0] CRS_SEL_DPB    = 4'h2;
   localparam logic [3:0] CRS_SEL_FLAGS  = 4'h3;
   localparam logic [3:0] CRS_SEL_IDX_X  = 4'h4;
   localparam logic [3:0] CRS_SEL_IDX_Y  = 4'h5;
   localparam logic [3:0] CRS_SEL_USP    = 4'h6;
   localparam logic [3:0] CRS_SEL_HSP    = 4'h7;
   localparam logic [3:0] CRS_SEL_IPTR   = 4'h8;
   localparam logic [3:0] CRS_SEL_ACC_D  = 4'h9;
   // Flag bit positions
   localparam int CRS_FLG_C = 0;
   localparam int CRS_FLG_V = 1;
   localparam int CRS_FLG_Z = 2;
   localparam int CRS_FLG_N = 3;
   localparam int CRS_FLG_I = 4;
   localparam int CRS_FLG_H = 5;
   localparam int CRS_FLG_F = 6;
   localparam int CRS_FLG_E = 7;
   // Reset values
   localparam logic [7:0]  CRS_DPB_RST   = 8'h00;
   localparam logic [7:0]  CRS_FLAGS_RST = 8'h50;
   localparam logic [15:0] CRS_WORD_RST  = 16'h0000;
   // Arithmetic operations
   localparam logic [2:0] CRS_OP_NONE = 3'h0;
   localparam logic [2:0] CRS_OP_ADD  = 3'h1;
   localparam logic [2:0] CRS_OP_ADC  = 3'h2;
   localparam logic [2:0] CRS_OP_SUB  = 3'h3;
   localparam logic [2:0] CRS_OP_SBC  = 3'h4;
   localparam logic [2:0] CRS_OP_CMP  = 3'h5;
   localparam logic [2:0] CRS_OP_NEG  = 3'h6;
   localparam logic [2:0] CRS_OP_LOG  = 3'h7;
   // Index base selection
   localparam logic [1:0] CRS_BASE_X = 2'h0;
   localparam logic [1:0] CRS_BASE_Y = 2'h1;
   localparam logic [1:0] CRS_BASE_U = 2'h2;
   localparam logic [1:0] CRS_BASE_S = 2'h3;
   // Index post-modification (increment or decrement)
   localparam logic [1:0] CRS_MOD_NONE = 2'h0;
   localparam logic [1:0] CRS_MOD_INC  = 2'h1;
   localparam logic [1:0] CRS_MOD_DEC  = 2'h2;
   // Interrupt and trap service kinds
   localparam logic [2:0] CRS_SVC_NONE  = 3'h0;
   localparam logic [2:0] CRS_SVC_UNMSK = 3'h1;
   localparam logic [2:0] CRS_SVC_FAST  = 3'h2;
   localparam logic [2:0] CRS_SVC_NORM  = 3'h3;
   localparam logic [2:0] CRS_SVC_TRAP  = 3'h4;
   localparam logic [2:0] CRS_SVC_TRAP2 = 3'h5;
   localparam logic [2:0] CRS_SVC_TRAP3 = 3'h6;
   // Hardware stack operations
   localparam logic [1:0] CRS_STK_NONE = 2'h0;
   localparam logic [1:0] CRS_STK_PUSH = 2'h1;
   localparam logic [1:0] CRS_STK_PULL = 2'h2;
endpackage

//--- tb_crs_regs.sv
// Self-checking testbench for the register set and condition flag block
`timescale 1ns/100ps
module tb_crs_regs;
   import crs_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        alu_valid = 1'b0;
   logic [2:0]  alu_op = 3'h0;
   logic        alu_wide = 1'b0;
   logic [15:0] alu_a = 16'h0000;
   logic [15:0] alu_b = 16'h0000;
   logic        direct_mode = 1'b0;
   logic [7:0]  direct_low = 8'h00;
   logic        index_mode = 1'b0;
   logic        rel_mode = 1'b0;
   logic [1:0]  index_base = 2'h0;
   logic [1:0]  index_mod = 2'h0;
   logic [15:0] index_offset = 16'h0000;
   logic        user_push = 1'b0;
   logic        user_pull = 1'b0;
   logic        ip_load = 1'b0;
   logic [15:0] ip_value = 16'h0000;
   logic [1:0]  stack_op = 2'h0;
   logic [2:0]  service_kind = 3'h0;
   logic        fast_interrupt_line_n = 1'b1;
   logic        normal_interrupt_line_n = 1'b1;
   logic [15:0] addr_out;
   logic [15:0] alu_result;
   logic [7:0]  flags_out;
   logic        fast_irq_take;
   logic        norm_irq_take;
   int          err_count = 0;
   int          tests_run = 0;
   // Flag expectations start from cleared flags for every entry
   logic [2:0]  t_op [9] = '{CRS_OP_ADD, CRS_OP_ADC, CRS_OP_ADD, CRS_OP_SUB, CRS_OP_SBC,
                             CRS_OP_CMP, CRS_OP_NEG, CRS_OP_LOG, CRS_OP_ADD};
   logic [15:0] t_a [9] = '{16'hA57F, 16'hA50F, 16'hA5FF, 16'hA500, 16'hA500, 16'hA500,
                             16'hA501, 16'hA500, 16'h7FFF};
   logic [15:0] t_b [9] = '{16'h5A01, 16'h5A01, 16'h5A01, 16'h5A01, 16'h5A01, 16'h5A01,
                             16'h5A00, 16'h5A00, 16'h0001};
   logic [7:0]  t_f [9] = '{8'h2A, 8'h20, 8'h25, 8'h09, 8'h09, 8'h09, 8'h09, 8'h04, 8'h0A};

   crs_regs uut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .alu_valid(alu_valid), .alu_op(alu_op), .alu_wide(alu_wide), .alu_a(alu_a),
      .alu_b(alu_b), .direct_mode(direct_mode), .direct_low(direct_low),
      .index_mode(index_mode), .rel_mode(rel_mode), .index_base(index_base),
      .index_mod(index_mod), .index_offset(index_offset), .user_push(user_push),
      .user_pull(user_pull), .ip_load(ip_load), .ip_value(ip_value), .stack_op(stack_op),
      .service_kind(service_kind), .fast_interrupt_line_n(fast_interrupt_line_n),
      .normal_interrupt_line_n(normal_interrupt_line_n), .addr_out(addr_out),
      .alu_result(alu_result), .flags_out(flags_out), .fast_irq_take(fast_irq_take),
      .norm_irq_take(norm_irq_take));

   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, exp);
   endtask

   // Lets a one-cycle strobe land, then the registered outputs settle
   task automatic land;
      @(posedge clk_sys);
      index_mode   <= 1'b0;
      rel_mode     <= 1'b0;
      direct_mode  <= 1'b0;
      alu_valid    <= 1'b0;
      ip_load      <= 1'b0;
      stack_op     <= CRS_STK_NONE;
      user_push    <= 1'b0;
      user_pull    <= 1'b0;
      service_kind <= CRS_SVC_NONE;
      index_mod    <= CRS_MOD_NONE;
      @(negedge clk_sys);
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #(25ns * 4000);
      err_count++;
      end_of_test;
   end

   initial
   begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      @(negedge clk_sys);
      chk({8'h00, flags_out}, 16'h0050);
      wr(CRS_SEL_ACC_A, 16'h00C3);
      wr(CRS_SEL_ACC_B, 16'h005A);
      rd(CRS_SEL_ACC_D, 16'hC35A);
      wr(CRS_SEL_ACC_D, 16'h1234);
      rd(CRS_SEL_ACC_A, 16'h0012);
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(CRS_SEL_ACC_A, 16'h0077);
      clk_en <= 1'b1;
      rd(CRS_SEL_ACC_A, 16'h0012);
      rd(4'hF, 16'h0000);
      wr(CRS_SEL_DPB, 16'h0012);
      @(posedge clk_sys);
      direct_mode <= 1'b1;
      direct_low  <= 8'h34;
      land;
      chk(addr_out, 16'h1234);
      for (int i = 0; i < 4; i++)
      begin
         wr(CRS_SEL_IDX_X + 4'(i), 16'h3000 + 16'(i * 256));
         @(posedge clk_sys);
         index_mode   <= 1'b1;
         index_base   <= 2'(i);
         index_mod    <= CRS_MOD_INC;
         index_offset <= 16'h0005;
         land;
         chk(addr_out, 16'h3005 + 16'(i * 256));
         rd(CRS_SEL_IDX_X + 4'(i), 16'h3001 + 16'(i * 256));
      end
      @(posedge clk_sys);
      index_mode   <= 1'b1;
      index_base   <= CRS_BASE_X;
      index_mod    <= CRS_MOD_DEC;
      index_offset <= 16'h0000;
      land;
      chk(addr_out, 16'h3001);
      rd(CRS_SEL_IDX_X, 16'h3000);
      @(posedge clk_sys);
      ip_load  <= 1'b1;
      ip_value <= 16'h4000;
      land;
      @(posedge clk_sys);
      rel_mode     <= 1'b1;
      index_offset <= 16'h0010;
      land;
      chk(addr_out, 16'h4010);
      rd(CRS_SEL_IPTR, 16'h4000);
      wr(CRS_SEL_HSP, 16'h1000);
      wr(CRS_SEL_USP, 16'h2000);
      @(posedge clk_sys);
      stack_op <= CRS_STK_PUSH;
      land;
      rd(CRS_SEL_HSP, 16'h0FFF);
      rd(CRS_SEL_USP, 16'h2000);
      @(posedge clk_sys);
      stack_op <= CRS_STK_PULL;
      land;
      rd(CRS_SEL_HSP, 16'h1000);
      @(posedge clk_sys);
      user_push <= 1'b1;
      land;
      rd(CRS_SEL_USP, 16'h1FFF);
      @(posedge clk_sys);
      user_pull <= 1'b1;
      land;
      rd(CRS_SEL_USP, 16'h2000);
      for (int k = 1; k < 7; k++)
      begin
         wr(CRS_SEL_FLAGS, 16'h0000);
         @(posedge clk_sys);
         service_kind <= 3'(k);
         land;
         chk({15'h0000, flags_out[CRS_FLG_I]}, {15'h0000, k < 5});
      end
      for (int j = 0; j < 9; j++)
      begin
         wr(CRS_SEL_FLAGS, 16'h0000);
         @(posedge clk_sys);
         alu_valid <= 1'b1;
         alu_op    <= t_op[j];
         alu_wide  <= (j == 8);
         alu_a     <= t_a[j];
         alu_b     <= t_b[j];
         land;
         chk({8'h00, flags_out}, {8'h00, t_f[j]});
         if (j == 0) chk(alu_result, 16'h0080);
         if (j == 8) chk(alu_result, 16'h8000);
      end
      wr(CRS_SEL_FLAGS, 16'h0050);
      fast_interrupt_line_n   <= 1'b0;
      normal_interrupt_line_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({14'h0000, fast_irq_take, norm_irq_take}, 16'h0000);
      wr(CRS_SEL_FLAGS, 16'h0040);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({14'h0000, fast_irq_take, norm_irq_take}, 16'h0001);
      wr(CRS_SEL_FLAGS, 16'h0010);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({15'h0000, fast_irq_take}, 16'h0001);
      fast_interrupt_line_n   <= 1'b1;
      normal_interrupt_line_n <= 1'b1;
      wr(CRS_SEL_DPB, 16'h00FF);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(CRS_SEL_DPB, 16'h0000);
      chk({8'h00, flags_out}, 16'h0050);
      end_of_test;
   end
endmodule
